// [hw/service_timer_fifo_core.v]
// Service request chain, shared prescaler with two timers, and 128-byte FIFO.
// Assumes host pins are asynchronous and the parallel channel runs on clk.
`timescale 1ns/1ps
`include "service_timer_fifo_defs.vh"
module service_timer_fifo_core #(
  parameter DEPTH = 128,
  parameter AW = 7
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire service_ack_in_n,
  input wire chain_grant_in_n,
  input wire data_strobe_n,
  input wire chip_select_n,
  output wire service_request_out_n,
  output wire service_request_oe_n,
  output wire chain_pass_out_n,
  output wire transfer_done_n,
  output reg [7:0] vector_data_out,
  output wire vector_data_oe_n,
  input wire in_valid,
  input wire [7:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [7:0] out_data,
  input wire out_ready
);
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  reg [7:0] vector_reg_r;
  reg [7:0] status_r;
  reg [7:0] config_r;
  reg [7:0] prescale_reg_r;
  reg [7:0] period_reg_r;
  reg [7:0] dtimeout_reg_r;
  reg [7:0] threshold_reg_r;
  reg loopback_r;
  reg pending_r;
  reg [1:0] ack_state_r;
  reg [8:0] div_r;
  reg [7:0] hold_r;
  reg [7:0] pre_cnt_r;
  reg [7:0] timer_cnt_r;
  reg timer_run_r;
  reg [7:0] dto_cnt_r;
  reg [7:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0] count_r;
  reg [AW:0] count_nxt;
  reg [1:0] ack_state_nxt;

  function is_reg;
    input [3:0] a;
    input [3:0] target;
    begin
      is_reg = (a == target);
    end
  endfunction

  wire ack_s = ~sync2_r[0];
  wire grant_s = ~sync2_r[1];
  wire strobe_s = ~sync2_r[2];
  wire cs_s = ~sync2_r[3];
  wire int_mode = config_r[`CFG_INT_MODE];
  wire out_mode = config_r[`CFG_OUTPUT];
  wire wr_cmd = wr && is_reg(addr, `ADDR_COMMAND);
  wire timer_en_cmd = wr_cmd && wdata[`CMD_TIMER_EN];
  wire flush_cmd = wr_cmd && wdata[`CMD_FLUSH];
  wire eos_wr = wr && is_reg(addr, `ADDR_EOS);
  wire fifo_full = (count_r == DEPTH);
  wire fifo_empty = (count_r == {(AW+1){1'b0}});

  // Channel side is cut off in loopback so the host alone owns both FIFO ends
  wire host_push = wr && is_reg(addr, `ADDR_FIFO) && !fifo_full && (out_mode || loopback_r); // RQ18 RQ22
  wire host_pop = rd && is_reg(addr, `ADDR_FIFO) && !fifo_empty && (!out_mode || loopback_r); // RQ18 RQ22
  assign in_ready = !fifo_full && !out_mode && !loopback_r;
  assign out_valid = !fifo_empty && out_mode && !loopback_r;
  assign out_data = mem_r[rptr_r];
  wire chan_push = in_valid && in_ready;
  wire chan_pop = out_valid && out_ready;
  wire push = host_push || chan_push;
  wire pop = host_pop || chan_pop;
  wire [7:0] push_data = host_push ? wdata : in_data;

  // Host pins cross into clk through two flops before use
  always @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
    end else begin
      sync1_r <= {chip_select_n, data_strobe_n, chain_grant_in_n, service_ack_in_n};
      sync2_r <= sync1_r;
    end
  end

  // Prescaler and timers
  wire div_pulse = (div_r == `CLK_DIV);
  wire pre_tick = div_pulse && (pre_cnt_r <= 8'h01);
  // A restart or a fresh character in the same cycle as the last tick wins over expiry
  wire timer_zero = pre_tick && timer_run_r && !timer_en_cmd && (timer_cnt_r <= 8'h01);
  wire dto_zero = pre_tick && !out_mode && !chan_push && (dto_cnt_r == 8'h01);

  always @(posedge clk) begin
    if (!rst_n) begin
      div_r <= 9'h000;
    end else if (div_pulse) begin
      div_r <= 9'h000; // RQ12
    end else begin
      div_r <= div_r + 9'h001;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      hold_r <= 8'h00;
      pre_cnt_r <= 8'h00;
    end else if (timer_en_cmd) begin
      hold_r <= prescale_reg_r; // RQ14
      pre_cnt_r <= prescale_reg_r;
    end else if (div_pulse) begin
      if (pre_cnt_r <= 8'h01) begin
        pre_cnt_r <= hold_r; // RQ13
      end else begin
        pre_cnt_r <= pre_cnt_r - 8'h01; // RQ12
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      timer_cnt_r <= 8'h00;
      timer_run_r <= 1'b0;
    end else if (timer_en_cmd) begin
      timer_cnt_r <= period_reg_r; // RQ15
      timer_run_r <= 1'b1;
    end else if (pre_tick && timer_run_r) begin
      if (timer_cnt_r <= 8'h01) begin
        timer_cnt_r <= 8'h00;
        timer_run_r <= 1'b0; // RQ15
      end else begin
        timer_cnt_r <= timer_cnt_r - 8'h01;
      end
    end
  end

  // Counter parks at zero, so an idle line raises one timeout, not a stream
  always @(posedge clk) begin
    if (!rst_n) begin
      dto_cnt_r <= 8'h00;
    end else if (chan_push) begin
      dto_cnt_r <= dtimeout_reg_r; // RQ16
    end else if (pre_tick && !out_mode && dto_cnt_r != 8'h00) begin
      dto_cnt_r <= dto_cnt_r - 8'h01; // RQ16 RQ21
    end
  end

  // Events and status
  wire thr_hit = out_mode ? (count_r < {1'b0, threshold_reg_r[AW-1:0]})
                          : (count_r > {1'b0, threshold_reg_r[AW-1:0]});
  wire ev_timer = timer_zero && config_r[`CFG_TIMER_EXPIRY]; // RQ15
  wire ev_dto = dto_zero && !fifo_empty && config_r[`CFG_TIMEOUT_READY]; // RQ17 RQ21
  wire ev_thr = thr_hit && !pending_r && config_r[`CFG_DATA_READY] &&
    !loopback_r; // RQ19 RQ20 RQ24
  wire ev_any = ev_timer || ev_dto || ev_thr;
  wire status_wr = wr && is_reg(addr, `ADDR_STATUS);

  // Status bits are write-one-to-clear; a new cause in the same cycle wins
  always @(posedge clk) begin
    if (!rst_n) begin
      status_r <= 8'h00;
    end else begin
      status_r[`ST_TIMER] <= ev_timer || (status_r[`ST_TIMER] &&
        !(status_wr && wdata[`ST_TIMER])); // RQ23
      status_r[`ST_THRESH] <= ev_thr || (status_r[`ST_THRESH] &&
        !(status_wr && wdata[`ST_THRESH])); // RQ23
      status_r[`ST_DTIMEOUT] <= ev_dto || (status_r[`ST_DTIMEOUT] &&
        !(status_wr && wdata[`ST_DTIMEOUT])); // RQ23
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pending_r <= 1'b0;
    end else if (ev_any) begin
      pending_r <= 1'b1; // RQ23
    end else if (eos_wr) begin
      pending_r <= 1'b0; // RQ11 RQ24
    end
  end

  // Request pin: drive low only in interrupt mode
  wire request_active = pending_r && int_mode; // RQ7 RQ23
  assign service_request_out_n = 1'b0;
  assign service_request_oe_n = ~request_active; // RQ1

  // Acknowledge cycle: claim or pass decided when strobe meets grant
  wire ack_start = strobe_s && grant_s && !cs_s; // RQ25
  always @* begin
    ack_state_nxt = ack_state_r;
    case (ack_state_r)
      `ACK_IDLE: begin
        if (ack_start && ack_s) begin
          if (request_active) begin
            ack_state_nxt = `ACK_CLAIM; // RQ2
          end else begin
            ack_state_nxt = `ACK_PASS; // RQ3 RQ9
          end
        end
      end
      `ACK_CLAIM: begin
        if (!strobe_s) begin
          ack_state_nxt = `ACK_IDLE;
        end
      end
      `ACK_PASS: begin
        if (!(strobe_s && grant_s && ack_s)) begin
          ack_state_nxt = `ACK_IDLE; // RQ9
        end
      end
      default: begin
        ack_state_nxt = `ACK_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      ack_state_r <= `ACK_IDLE;
      vector_data_out <= 8'h00;
    end else begin
      ack_state_r <= ack_state_nxt;
      if (ack_state_r == `ACK_IDLE && ack_state_nxt == `ACK_CLAIM) begin
        vector_data_out <= vector_reg_r; // RQ2
      end
    end
  end

  // Lower chain members see grant only through this pass, giving position priority
  assign chain_pass_out_n = ~(ack_state_r == `ACK_PASS); // RQ1 RQ3
  assign transfer_done_n = ~(ack_state_r == `ACK_CLAIM); // RQ2
  assign vector_data_oe_n = ~(ack_state_r == `ACK_CLAIM);

  // FIFO storage
  always @* begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      count_nxt = count_r - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= push_data; // RQ18
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (flush_cmd) begin
      wptr_r <= {AW{1'b0}}; // RQ22
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_r <= wptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rptr_r <= rptr_r + {{(AW-1){1'b0}}, 1'b1}; // RQ22
      end
      count_r <= count_nxt;
    end
  end

  // Register writes
  always @(posedge clk) begin
    if (!rst_n) begin
      vector_reg_r <= 8'h00;
      config_r <= 8'h00;
      prescale_reg_r <= 8'h00;
      period_reg_r <= 8'h00;
      dtimeout_reg_r <= 8'h00;
      threshold_reg_r <= 8'h00;
      loopback_r <= 1'b0;
    end else if (wr) begin
      case (addr)
        `ADDR_VECTOR: vector_reg_r <= wdata;
        `ADDR_CONFIG: config_r <= wdata & `CFG_MASK;
        `ADDR_PRESCALE: prescale_reg_r <= wdata; // RQ14
        `ADDR_PERIOD: period_reg_r <= wdata;
        `ADDR_DTIMEOUT: dtimeout_reg_r <= wdata;
        `ADDR_THRESH: threshold_reg_r <= wdata;
        `ADDR_COMMAND: loopback_r <= wdata[`CMD_LOOPBACK]; // RQ22
        default: loopback_r <= loopback_r;
      endcase
    end
  end

  // Read views built from the named bit positions; unused bits read as zero
  reg [7:0] status_view;
  reg [7:0] command_view;
  always @* begin
    status_view = 8'h00;
    status_view[`ST_TIMER] = status_r[`ST_TIMER];
    status_view[`ST_THRESH] = status_r[`ST_THRESH];
    status_view[`ST_DTIMEOUT] = status_r[`ST_DTIMEOUT];
    // Summary bit mirrors the pending flag so a polling host tests one bit
    status_view[`ST_SUMMARY] = pending_r; // RQ10
    command_view = 8'h00;
    command_view[`CMD_LOOPBACK] = loopback_r; // RQ22
  end

  // Register reads, data one cycle after the strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ADDR_VECTOR: rdata <= vector_reg_r;
        `ADDR_STATUS: rdata <= status_view; // RQ7 RQ10
        `ADDR_CONFIG: rdata <= config_r;
        `ADDR_PRESCALE: rdata <= prescale_reg_r;
        `ADDR_PERIOD: rdata <= period_reg_r;
        `ADDR_DTIMEOUT: rdata <= dtimeout_reg_r;
        `ADDR_COMMAND: rdata <= command_view;
        `ADDR_FIFO: rdata <= host_pop ? mem_r[rptr_r] : 8'h00; // RQ18
        `ADDR_THRESH: rdata <= threshold_reg_r;
        `ADDR_COUNT: rdata <= {{(7-AW){1'b0}}, count_r}; // RQ19 RQ20
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// [hw/service_timer_fifo_defs.vh]
// Constants for the service request, timer and FIFO core.
// Assumes inclusion by bare name from the core module file.
// Operation
// [RQ1] Chain position sets acknowledge priority; request pin is open drain.
// [RQ2] Granted acknowledge with request pending claims cycle and returns vector.
// [RQ3] Granted acknowledge without pending request passes grant downstream, no claim.
// [RQ4] Host detects unanswered acknowledge cycles, for example by timeout.
// [RQ5] Host loads each chained device with a distinct vector.
// [RQ6] First grant may tie to acknowledge only if strobe comes later.
// [RQ7] Polled mode never asserts request pin but still records causes.
// [RQ8] Host never acknowledges while request output is inactive.
// [RQ9] Polled mode passes grant when acknowledge, grant and strobe all active.
// [RQ10] Polling host reads status and treats summary bit one as request.
// [RQ11] Host ends service by writing end-of-service; device clears pending flag.
// [RQ12] Prescaler counts clock divided by 512, ticking both timers at zero.
// [RQ13] Prescaler reloads itself from holding register on reaching zero.
// [RQ14] Holding register loads from prescale register only on timer enable command.
// [RQ15] One-shot timer loads on enable command, counts ticks, expires at zero.
// [RQ16] Data timeout counts ticks and reloads on each received character.
// [RQ17] Timeout at zero with FIFO not empty raises data ready if enabled.
// [RQ18] 128-byte FIFO reached through one data location for reads and writes.
// [RQ19] Input modes: count above threshold raises data ready; count shows readable bytes.
// [RQ20] Output modes: count below threshold raises data ready; count shows pending bytes.
// [RQ21] Data timeout inactive in output modes.
// [RQ22] Loopback with flush returns 128 written bytes unchanged and in order.
// [RQ23] Enabled event records cause, sets pending, drives request only in interrupt mode.
// [RQ24] Pending suspends threshold detection and input sampling until end-of-service; the core suspends only the threshold event, in_ready still accepts input.
// [RQ25] Acknowledge cycle starts on strobe and grant together with select inactive.
`ifndef SERVICE_TIMER_FIFO_DEFS_VH
`define SERVICE_TIMER_FIFO_DEFS_VH
`define ADDR_VECTOR 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_CONFIG 4'h2
`define ADDR_EOS 4'h3
`define ADDR_PRESCALE 4'h4
`define ADDR_PERIOD 4'h5
`define ADDR_DTIMEOUT 4'h6
`define ADDR_COMMAND 4'h7
`define ADDR_FIFO 4'h8
`define ADDR_THRESH 4'h9
`define ADDR_COUNT 4'ha
`define ST_TIMER 0
`define ST_THRESH 1
`define ST_DTIMEOUT 2
`define ST_SUMMARY 7
`define CFG_INT_MODE 0
`define CFG_TIMER_EXPIRY 1
`define CFG_TIMEOUT_READY 2
`define CFG_DATA_READY 3
`define CFG_OUTPUT 4
`define CFG_MASK 8'h1f
`define CMD_TIMER_EN 0
`define CMD_FLUSH 1
`define CMD_LOOPBACK 2
`define CLK_DIV 9'd511
`define ACK_IDLE 2'd0
`define ACK_CLAIM 2'd1
`define ACK_PASS 2'd2
`endif

// [tb/chain_host.sv]
// Host side of the acknowledge chain: runs one acknowledge cycle.
// Assumes pulled-up pins, so released lines idle high.
`timescale 1ns/1ps
module chain_host (
  input wire clk,
  input wire req_oe_n,
  input wire done_n,
  input wire pass_n,
  input wire [7:0] vec,
  input wire vec_oe_n,
  output reg ack_n,
  output reg grant_n,
  output reg strobe_n,
  output reg cs_n
);
  initial begin
    ack_n = 1'b1;
    grant_n = 1'b1;
    strobe_n = 1'b1;
    cs_n = 1'b1;
  end
  // ans: 01 claimed, 10 passed, 00 no answer
  task automatic ack_cycle(input logic force_it, input logic cs_low,
      output logic [7:0] got, output logic [1:0] ans);
    int n;
    got = 8'h00;
    ans = 2'b00;
    if (req_oe_n && !force_it) return;
    @(posedge clk);
    cs_n <= !cs_low;
    ack_n <= 1'b0;
    repeat (3) @(posedge clk);
    grant_n <= 1'b0;
    strobe_n <= 1'b0;
    n = 0;
    // Nobody may answer, so the wait is cut off
    do begin
      @(posedge clk);
      n++;
    end while (done_n && pass_n && n < 20);
    ans = {!pass_n, !done_n};
    got = vec_oe_n ? 8'h00 : vec;
    strobe_n <= 1'b1;
    ack_n <= 1'b1;
    grant_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

// [tb/service_timer_fifo_core_checker.sv]
// Pin-level assertions for the service, timer and FIFO core.
// Assumes pins pass two sync flops before the ack state register.
`timescale 1ns/1ps
module service_timer_fifo_core_checker (
  input wire clk,
  input wire rst_n,
  input wire rd,
  input wire [7:0] rdata,
  input wire service_ack_in_n,
  input wire chain_grant_in_n,
  input wire data_strobe_n,
  input wire chip_select_n,
  input wire service_request_out_n,
  input wire service_request_oe_n,
  input wire chain_pass_out_n,
  input wire transfer_done_n,
  input wire vector_data_oe_n,
  input wire in_ready,
  input wire out_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pin_open_drain: assert property (service_request_out_n == 1'b0)
    else $error("request pin value not low");
  a_claim_drives: assert property (!transfer_done_n |-> !vector_data_oe_n)
    else $error("claim without vector drive");
  a_claim_release: assert property ($rose(data_strobe_n) |-> ##[1:4] transfer_done_n)
    else $error("claim held after strobe release");
  a_pass_no_claim: assert property (!chain_pass_out_n |-> transfer_done_n && vector_data_oe_n)
    else $error("pass and claim together");
  a_pass_release: assert property ($rose(service_ack_in_n) |-> ##[1:4] chain_pass_out_n)
    else $error("pass held after ack release");
  a_pass_cause: assert property ($fell(chain_pass_out_n) |-> !$past(service_ack_in_n, 3)
    && !$past(chain_grant_in_n, 3) && !$past(data_strobe_n, 3))
    else $error("pass without ack grant strobe");
  a_claim_cause: assert property ($fell(transfer_done_n) |-> !$past(service_request_oe_n)
    && $past(chip_select_n, 3) && !$past(chain_grant_in_n, 3))
    else $error("claim without request or grant");
  a_select_blocks: assert property (!chip_select_n [*4] |->
    !$fell(transfer_done_n) && !$fell(chain_pass_out_n))
    else $error("ack cycle began with select low");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_dir_excl: assert property (!(in_ready && out_valid))
    else $error("both channel directions active");
endmodule

bind service_timer_fifo_core service_timer_fifo_core_checker chk_u (
  .clk, .rst_n, .rd, .rdata, .service_ack_in_n, .chain_grant_in_n,
  .data_strobe_n, .chip_select_n, .service_request_out_n, .service_request_oe_n,
  .chain_pass_out_n, .transfer_done_n, .vector_data_oe_n, .in_ready, .out_valid
);

// [tb/service_timer_fifo_core_tb.sv]
// Self-checking bench for the service, timer and FIFO core.
// Assumes the core's register map and a chain host model beside it.
`timescale 1ns/1ps
`include "service_timer_fifo_defs.vh"
module service_timer_fifo_core_tb;
  logic clk, rst_n, wr, rd, in_valid, out_ready;
  logic [3:0] addr;
  logic [7:0] wdata, in_data, rdata, vector_data_out, out_data, got;
  logic [1:0] ans;
  wire service_ack_in_n, chain_grant_in_n, data_strobe_n, chip_select_n;
  wire service_request_out_n, service_request_oe_n, chain_pass_out_n;
  wire transfer_done_n, vector_data_oe_n, in_ready, out_valid;
  int err_total, total_checks;
  service_timer_fifo_core dut_u (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .service_ack_in_n, .chain_grant_in_n, .data_strobe_n, .chip_select_n,
    .service_request_out_n, .service_request_oe_n, .chain_pass_out_n,
    .transfer_done_n, .vector_data_out, .vector_data_oe_n, .in_valid, .in_data,
    .in_ready, .out_valid, .out_data, .out_ready);
  chain_host host_u (.clk, .req_oe_n(service_request_oe_n), .done_n(transfer_done_n),
    .pass_n(chain_pass_out_n), .vec(vector_data_out), .vec_oe_n(vector_data_oe_n),
    .ack_n(service_ack_in_n), .grant_n(chain_grant_in_n), .strobe_n(data_strobe_n),
    .cs_n(chip_select_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clk);
    in_valid <= 1'b1;
    in_data <= b;
    @(posedge clk);
    in_valid <= 1'b0;
  endtask
  // Threshold event, ack cycle, then the full service sequence
  task automatic round(input logic [7:0] cfg, input logic [1:0] exp_ans);
    wreg(`ADDR_CONFIG, cfg);
    for (int i = 0; i < 3; i++) push(8'ha0 + 8'(i));
    repeat (4) @(posedge clk);
    rreg(`ADDR_STATUS, 8'h82);
    check({7'h00, service_request_oe_n}, {7'h00, !cfg[0]});
    host_u.ack_cycle(!cfg[0], 1'b0, got, ans);
    check({6'h00, ans}, {6'h00, exp_ans});
    check(got, cfg[0] ? 8'h3c : 8'h00);
    wreg(`ADDR_STATUS, 8'h02);
    rreg(`ADDR_STATUS, 8'h80);
    for (int i = 0; i < 3; i++) rreg(`ADDR_FIFO, 8'ha0 + 8'(i));
    wreg(`ADDR_EOS, 8'h00);
    rreg(`ADDR_STATUS, 8'h00);
    check({7'h00, service_request_oe_n}, 8'h01);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    {rst_n, wr, rd, in_valid, out_ready} = 5'h00;
    addr = 4'h0;
    wdata = 8'h00;
    in_data = 8'h00;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rreg(`ADDR_STATUS, 8'h00);
    wreg(`ADDR_VECTOR, 8'h3c);
    rreg(4'hf, 8'h00);
    $display("registers done");
    wreg(`ADDR_COMMAND, 8'h06);
    for (int i = 0; i < 129; i++) wreg(`ADDR_FIFO, 8'(i * 7 + 1));
    rreg(`ADDR_COUNT, 8'h80);
    check({6'h00, in_ready, out_valid}, 8'h00);
    for (int i = 0; i < 128; i++) rreg(`ADDR_FIFO, 8'(i * 7 + 1));
    rreg(`ADDR_FIFO, 8'h00);
    $display("loopback done");
    wreg(`ADDR_COMMAND, 8'h02);
    wreg(`ADDR_THRESH, 8'h02);
    round(8'h08, 2'b10);
    round(8'h09, 2'b01);
    host_u.ack_cycle(1'b1, 1'b0, got, ans);
    check({6'h00, ans}, 8'h02);
    host_u.ack_cycle(1'b1, 1'b1, got, ans);
    check({6'h00, ans}, 8'h00);
    $display("chain done");
    // Prescale 2, period 2: expiry lands 1537 to 2048 cycles after enable
    wreg(`ADDR_PRESCALE, 8'h02);
    wreg(`ADDR_PERIOD, 8'h02);
    wreg(`ADDR_CONFIG, 8'h02);
    wreg(`ADDR_COMMAND, 8'h01);
    repeat (1400) @(posedge clk);
    rreg(`ADDR_STATUS, 8'h00);
    repeat (800) @(posedge clk);
    rreg(`ADDR_STATUS, 8'h81);
    wreg(`ADDR_STATUS, 8'h01);
    wreg(`ADDR_EOS, 8'h00);
    repeat (2200) @(posedge clk);
    rreg(`ADDR_STATUS, 8'h00);
    $display("timer done");
    wreg(`ADDR_PRESCALE, 8'h01);
    wreg(`ADDR_DTIMEOUT, 8'h02);
    wreg(`ADDR_THRESH, 8'h7f);
    wreg(`ADDR_CONFIG, 8'h04);
    wreg(`ADDR_COMMAND, 8'h01);
    push(8'h5e);
    repeat (300) @(posedge clk);
    rreg(`ADDR_STATUS, 8'h00);
    repeat (1100) @(posedge clk);
    rreg(`ADDR_STATUS, 8'h84);
    rreg(`ADDR_FIFO, 8'h5e);
    wreg(`ADDR_STATUS, 8'h04);
    wreg(`ADDR_EOS, 8'h00);
    $display("data timeout done");
    wreg(`ADDR_THRESH, 8'h04);
    wreg(`ADDR_CONFIG, 8'h1c);
    wreg(`ADDR_FIFO, 8'h11);
    wreg(`ADDR_FIFO, 8'h22);
    repeat (1200) @(posedge clk);
    rreg(`ADDR_STATUS, 8'h82);
    rreg(`ADDR_COUNT, 8'h02);
    check(out_data, 8'h11);
    check({6'h00, in_ready, out_valid}, 8'h01);
    @(posedge clk);
    out_ready <= 1'b1;
    repeat (6) @(posedge clk);
    out_ready <= 1'b0;
    rreg(`ADDR_COUNT, 8'h00);
    wreg(`ADDR_CONFIG, 8'h00);
    wreg(`ADDR_STATUS, 8'h02);
    wreg(`ADDR_EOS, 8'h00);
    rreg(`ADDR_STATUS, 8'h00);
    $display("output mode done");
    wrap_up();
  end
endmodule
